// >>> common/egress_action_pkg.sv
package egress_action_pkg;

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [5:0] OFS_SELECT   = 6'h00;
  localparam logic [5:0] OFS_CONSTS   = 6'h04;
  localparam logic [5:0] OFS_LABEL    = 6'h08;
  localparam logic [5:0] OFS_ENCAP    = 6'h0C;
  localparam logic [5:0] OFS_SERVICE  = 6'h10;
  localparam logic [5:0] OFS_CLASSOFS = 6'h14;
  localparam logic [5:0] OFS_MAPIDX   = 6'h18;
  localparam logic [5:0] OFS_MAPKEY   = 6'h1C;
  localparam logic [5:0] OFS_STATUS   = 6'h20;

  // ************************************************************
  // field positions, select register
  // ************************************************************
  localparam int POS_VLAN_SRC  = 0;
  localparam int POS_DIFFSERV_SOURCE_SELECT  = 1;
  localparam int POS_PROT_SEL  = 4;
  localparam int POS_LABEL_SEL = 6;
  localparam int POS_TRAFFIC_CLASS_SOURCE    = 9;
  localparam int POS_BOS_SRC   = 12;
  localparam int POS_TTL_SRC   = 13;
  localparam int POS_CW_OFF    = 14;
  localparam int POS_POP_CNT   = 15;

  // ************************************************************
  // field positions, constants / encap / service registers
  // ************************************************************
  localparam int POS_VLAN_CONST = 0;
  localparam int POS_DSCP_CONST = 12;
  localparam int POS_TC_CONST   = 18;
  localparam int POS_BOS_CONST  = 21;
  localparam int POS_TTL_CONST  = 22;
  localparam int POS_ENCAP      = 0;
  localparam int POS_ENCAP_PROT = 8;
  localparam int POS_BASE       = 0;
  localparam int POS_BASE_PROT  = 16;
  localparam int POS_MEP        = 0;
  localparam int POS_MEP_PROT   = 16;

  localparam logic [31:0] RESET_VALUE = 32'h0000_0000;

  // ************************************************************
  // encodings and limits
  // ************************************************************
  localparam logic [1:0] PROT_NEVER     = 2'h0;
  localparam logic [1:0] PROT_WHEN_ON   = 2'h1;
  localparam logic [1:0] PROT_WHEN_OFF  = 2'h2;
  localparam logic [4:0] POP_MAX_CODE   = 5'h15;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

endpackage

// >>> hdl/egress_action_field_select.sv
`timescale 1ns/10ps

// Contract
// - vlan source 0 gives classified vid, 1 gives configured vid
// - dscp source 0 port decides, 1 classified, 2 constant, 3 reserved
// - dscp codes 4..7 use tables 0..3 with fallback chain on miss
// - protection select 1 substitutes when active, 2 when inactive
// - label source 0 constant, 4..7 mapping tables 0..3, 1..3 reserved
// - tc source classified, constant, class id, or mapped with fallback
// - bottom-of-stack source 0 classified, 1 constant
// - hop limit source 0 classified, 1 constant
// - control word off field forces no control word, else control_word_on input decides
// - encapsulation index zero disables push, 1..127 selects entry
// - protected encapsulation index replaces normal when substituting
// - pop code 0 header count, 1 nothing, 2..21 twice code bytes
// - header count wins when the field would pop more bytes
// - service base index selects the egress counter set
// - protected service base replaces normal when substituting
// - statistics index is base plus 3-bit per-class offset
// - mapping index gives address bits 10:3, key gives low bits
// - tables 0 and 1 use resource A, tables 2 and 3 resource B
// - each table has a 4-bit key selector choosing the frame attributes
module egress_action_field_select
  import egress_action_pkg::*;
#(
  parameter int MEP_W = 11,
  parameter int POPW  = 5
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // axi4-lite slave
  input  wire logic [5:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [5:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // per-frame header metadata
  input  wire logic              frameValid,
  input  wire logic [11:0]       classVlan,
  input  wire logic [5:0]        classDscp,
  input  wire logic [2:0]        classTc,
  input  wire logic              classBottomStack,
  input  wire logic [7:0]        classHopLimit,
  input  wire logic [2:0]        class_of_service_id,
  input  wire logic [2:0]        qosClass,
  input  wire logic [1:0]        dropPrec,
  input  wire logic [2:0]        framePcp,
  input  wire logic              frameDei,
  input  wire logic [2:0]        poppedPcp,
  input  wire logic              poppedDei,
  input  wire logic              protActive,
  input  wire logic [POPW-1:0]   headerWordPop,
  input  wire logic              control_word_on,
  // mapping lookup answer, valid while mapAddrValid is high
  input  wire logic [3:0]        mapHit,
  input  wire logic [23:0]       mapDscp,
  input  wire logic [11:0]       mapTc,
  input  wire logic [79:0]       mapLabel,
  // mapping lookup request
  output logic                   mapAddrValid,
  output logic [21:0]            resourceAAddr,
  output logic [21:0]            resourceBAddr,
  // results to the rewriter
  output logic                   resultValid,
  output logic [11:0]            customer_tag_vlan_result,
  output logic                   diffservFromPort,
  output logic [5:0]             diffservResult,
  output logic [19:0]            labelResult,
  output logic [2:0]             trafficClassResult,
  output logic                   bottomStackResult,
  output logic [7:0]             hopLimitResult,
  output logic                   controlWordResult,
  output logic                   encapPush,
  output logic [6:0]             encapIndexResult,
  output logic [MEP_W-1:0]       endpointIndexResult,
  output logic [9:0]             statIndexResult,
  output logic [5:0]             popBytesResult
);

  // ************************************************************
  // register file
  // ************************************************************
  logic [31:0] regSelect, regConsts, regLabel, regEncap;
  logic [31:0] regService, regClassOfs, regMapIdx, regMapKey;
  logic [15:0] frameCount;
  logic        awHeld, wHeld;
  logic [5:0]  awAddr;
  logic [31:0] wData;
  logic [3:0]  wStrb;

  function automatic logic mapped(input logic [5:0] a);
    return a == OFS_SELECT || a == OFS_CONSTS || a == OFS_LABEL ||
           a == OFS_ENCAP || a == OFS_SERVICE || a == OFS_CLASSOFS ||
           a == OFS_MAPIDX || a == OFS_MAPKEY || a == OFS_STATUS;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire        doWrite  = awHeld && wHeld;
  wire [31:0] endpointReg = regEncap;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      awAddr <= 6'h00;
      wData  <= 32'h0000_0000;
      wStrb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      regSelect   <= RESET_VALUE;
      regConsts   <= RESET_VALUE;
      regLabel    <= RESET_VALUE;
      regEncap    <= RESET_VALUE;
      regService  <= RESET_VALUE;
      regClassOfs <= RESET_VALUE;
      regMapIdx   <= RESET_VALUE;
      regMapKey   <= RESET_VALUE;
    end else if (doWrite) begin
      unique case (awAddr)
        OFS_SELECT:   regSelect   <= merge(regSelect, wData, wStrb);
        OFS_CONSTS:   regConsts   <= merge(regConsts, wData, wStrb);
        OFS_LABEL:    regLabel    <= merge(regLabel, wData, wStrb);
        OFS_ENCAP:    regEncap    <= merge(regEncap, wData, wStrb);
        OFS_SERVICE:  regService  <= merge(regService, wData, wStrb);
        OFS_CLASSOFS: regClassOfs <= merge(regClassOfs, wData, wStrb);
        OFS_MAPIDX:   regMapIdx   <= merge(regMapIdx, wData, wStrb);
        OFS_MAPKEY:   regMapKey   <= merge(regMapKey, wData, wStrb);
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      // status is read-only, so a write there is an error too
      s_axi_bresp  <= (mapped(awAddr) && awAddr != OFS_STATUS) ?
                      RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        OFS_SELECT:   s_axi_rdata <= regSelect;
        OFS_CONSTS:   s_axi_rdata <= regConsts;
        OFS_LABEL:    s_axi_rdata <= regLabel;
        OFS_ENCAP:    s_axi_rdata <= regEncap;
        OFS_SERVICE:  s_axi_rdata <= regService;
        OFS_CLASSOFS: s_axi_rdata <= regClassOfs;
        OFS_MAPIDX:   s_axi_rdata <= regMapIdx;
        OFS_MAPKEY:   s_axi_rdata <= regMapKey;
        OFS_STATUS:   s_axi_rdata <= {10'h000, popBytesResult, frameCount};
        default:      s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ************************************************************
  // stage 1: mapping addresses, frame held
  // ************************************************************
  logic [11:0] hVlan;
  logic [5:0]  hDscp;
  logic [2:0]  hTc, hCos;
  logic        hBos, hProt;
  logic [7:0]  hTtl;
  logic [POPW-1:0] hWordPop;
  logic        hCwOn;
  logic [43:0] nextMapAddr;

  // low offset from the key selector; wider keys carry into bits 10:3
  function automatic logic [10:0] keyOffset(input logic [3:0] key);
    unique case (key)
      4'h0:    return {8'h00, qosClass};
      4'h1:    return {6'h00, dropPrec, qosClass};
      4'h2:    return {5'h00, classDscp};
      4'h3:    return {3'h0, dropPrec, classDscp};
      4'h4:    return {6'h00, dropPrec, classDscp[5:3]};
      4'h5:    return {8'h00, framePcp};
      4'h6:    return {6'h00, dropPrec, framePcp};
      4'h7:    return {7'h00, frameDei, framePcp};
      4'h8:    return {8'h00, classTc};
      4'h9:    return {6'h00, dropPrec, classTc};
      4'hA:    return {8'h00, poppedPcp};
      4'hB:    return {6'h00, dropPrec, poppedPcp};
      4'hC:    return {7'h00, poppedDei, poppedPcp};
      4'hD:    return {8'h00, class_of_service_id};
      default: return {6'h00, dropPrec, class_of_service_id};
    endcase
  endfunction

  for (genvar t = 0; t < 4; t++) begin : g_addr
    assign nextMapAddr[11*t +: 11] =
      {regMapIdx[8*t +: 8], 3'b000} + keyOffset(regMapKey[4*t +: 4]);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mapAddrValid  <= 1'b0;
      resourceAAddr <= 22'h00_0000;
      resourceBAddr <= 22'h00_0000;
      hVlan <= 12'h000;
      hDscp <= 6'h00;
      hTc   <= 3'h0;
      hCos  <= 3'h0;
      hBos  <= 1'b0;
      hTtl  <= 8'h00;
      hProt <= 1'b0;
      hWordPop <= '0;
      hCwOn <= 1'b0;
    end else begin
      mapAddrValid <= frameValid;
      if (frameValid) begin
        resourceAAddr <= nextMapAddr[21:0];
        resourceBAddr <= nextMapAddr[43:22];
        hVlan <= classVlan;
        hDscp <= classDscp;
        hTc   <= classTc;
        hCos  <= class_of_service_id;
        hBos  <= classBottomStack;
        hTtl  <= classHopLimit;
        hProt <= protActive;
        hWordPop <= headerWordPop;
        hCwOn <= control_word_on;
      end
    end
  end

  // ************************************************************
  // stage 2: field selection
  // ************************************************************
  wire [2:0] dscpSel  = regSelect[POS_DIFFSERV_SOURCE_SELECT +: 3];
  wire [1:0] protSel  = regSelect[POS_PROT_SEL +: 2];
  wire [2:0] labelSel = regSelect[POS_LABEL_SEL +: 3];
  wire [2:0] tcSel    = regSelect[POS_TRAFFIC_CLASS_SOURCE +: 3];
  wire [4:0] popCode  = regSelect[POS_POP_CNT +: 5];
  wire [5:0] dscpConst = regConsts[POS_DSCP_CONST +: 6];
  wire [2:0] tcConst   = regConsts[POS_TC_CONST +: 3];

  // miss chain: 4,6 fall to the constant, 5 to table 0, 7 to table 2
  function automatic logic [5:0] chain(input logic [1:0] t,
                                       input logic [3:0] hit,
                                       input logic [23:0] v,
                                       input logic [5:0] c);
    logic [5:0] r;
    r = c;
    if (t[0] && hit[{t[1], 1'b0}]) begin
      r = v[6*{t[1], 1'b0} +: 6];
    end
    if (hit[t]) begin
      r = v[6*t +: 6];
    end
    return r;
  endfunction

  logic [23:0] tcWide;
  for (genvar t = 0; t < 4; t++) begin : g_tc
    assign tcWide[6*t +: 6] = {3'b000, mapTc[3*t +: 3]};
  end

  wire subst = (protSel == PROT_WHEN_ON && hProt) ||
               (protSel == PROT_WHEN_OFF && !hProt);

  logic [5:0] next_pop, headerBytes, fieldBytes;
  always_comb begin
    headerBytes = 6'({hWordPop, 1'b0});
    fieldBytes  = 6'({popCode, 1'b0});
    if (popCode == 5'h00 || popCode > POP_MAX_CODE) begin
      next_pop = headerBytes;
    end else if (popCode == 5'h01) begin
      next_pop = 6'h00;
    end else if (fieldBytes > headerBytes) begin
      next_pop = headerBytes;
    end else begin
      next_pop = fieldBytes;
    end
  end

  logic [5:0] next_dscp;
  logic [2:0] next_tc;
  logic [19:0] next_label;
  always_comb begin
    next_dscp = hDscp;
    unique case (dscpSel)
      3'h1:    next_dscp = hDscp;
      3'h2:    next_dscp = dscpConst;
      3'h4, 3'h5, 3'h6, 3'h7:
        next_dscp = chain(dscpSel[1:0], mapHit, mapDscp, dscpConst);
      default: next_dscp = hDscp;
    endcase
    next_tc = hTc;
    unique case (tcSel)
      3'h1:    next_tc = tcConst;
      3'h2:    next_tc = hCos;
      3'h4, 3'h5, 3'h6, 3'h7:
        next_tc = 3'(chain(tcSel[1:0], mapHit, tcWide, {3'b000, tcConst}));
      default: next_tc = hTc;
    endcase
    // a label lookup that misses keeps the configured label
    next_label = regLabel[19:0];
    if (labelSel[2] && mapHit[labelSel[1:0]]) begin
      next_label = mapLabel[20*labelSel[1:0] +: 20];
    end
  end

  wire [6:0] encapSel = subst ? regEncap[POS_ENCAP_PROT +: 7]
                              : regEncap[POS_ENCAP +: 7];
  wire [9:0] baseSel  = subst ? regService[POS_BASE_PROT +: 10]
                              : regService[POS_BASE +: 10];
  wire [2:0] classOfs = regClassOfs[3*hCos +: 3];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      resultValid <= 1'b0;
      customer_tag_vlan_result <= 12'h000;
      diffservFromPort <= 1'b0;
      diffservResult <= 6'h00;
      labelResult <= 20'h0_0000;
      trafficClassResult <= 3'h0;
      bottomStackResult <= 1'b0;
      hopLimitResult <= 8'h00;
      controlWordResult <= 1'b0;
      encapPush <= 1'b0;
      encapIndexResult <= 7'h00;
      endpointIndexResult <= '0;
      statIndexResult <= 10'h000;
      popBytesResult <= 6'h00;
    end else begin
      resultValid <= mapAddrValid;
      if (mapAddrValid) begin
        customer_tag_vlan_result <= regSelect[POS_VLAN_SRC] ?
          regConsts[POS_VLAN_CONST +: 12] : hVlan;
        diffservFromPort <= dscpSel == 3'h0 || dscpSel == 3'h3;
        diffservResult <= next_dscp;
        labelResult <= next_label;
        trafficClassResult <= next_tc;
        bottomStackResult <= regSelect[POS_BOS_SRC] ?
          regConsts[POS_BOS_CONST] : hBos;
        hopLimitResult <= regSelect[POS_TTL_SRC] ?
          regConsts[POS_TTL_CONST +: 8] : hTtl;
        controlWordResult <= !regSelect[POS_CW_OFF] && hCwOn;
        encapPush <= encapSel != 7'h00;
        encapIndexResult <= encapSel;
        endpointIndexResult <= subst ?
          endpointReg[POS_MEP_PROT +: MEP_W] : '0;
        statIndexResult <= baseSel + {7'h00, classOfs};
        popBytesResult <= next_pop;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      frameCount <= 16'h0000;
    end else if (mapAddrValid) begin
      frameCount <= frameCount + 16'h0001;
    end
  end

endmodule // egress_action_field_select

// >>> verif/egress_action_checker.sv
`timescale 1ns/10ps
module egress_action_checker
  import egress_action_pkg::*;
#(
  parameter int POPW = 5
) (
  input wire logic            sys_clk,
  input wire logic            rst_n,
  input wire logic            frameValid,
  input wire logic            control_word_on,
  input wire logic [POPW-1:0] headerWordPop,
  input wire logic            mapAddrValid,
  input wire logic            resultValid,
  input wire logic            controlWordResult,
  input wire logic            encapPush,
  input wire logic [6:0]      encapIndexResult,
  input wire logic [19:0]     labelResult,
  input wire logic [9:0]      statIndexResult,
  input wire logic [5:0]      diffservResult,
  input wire logic [5:0]      popBytesResult
);
  // ********************
  // frame path timing
  // ********************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_frame;
    frameValid;
  endsequence
  sequence s_answer;
    ##1 mapAddrValid ##1 resultValid;
  endsequence
  a_frame_answer: assert property (s_frame |-> s_answer)
    else $error("frame not answered in two cycles");
  a_map_cause: assert property (mapAddrValid |-> $past(frameValid))
    else $error("lookup without a frame");
  a_result_cause: assert property (resultValid |-> $past(mapAddrValid))
    else $error("result without a lookup");
  // no control word may appear while control_word_on is low
  a_cw_off: assert property (frameValid && !control_word_on |->
    ##2 !controlWordResult)
    else $error("control word without enable");
  a_pop_bound: assert property (frameValid |->
    ##2 popBytesResult <= {$past(headerWordPop, 2), 1'b0})
    else $error("pop exceeds header count");
  a_pop_even: assert property (resultValid |-> !popBytesResult[0])
    else $error("odd pop byte count");
  a_encap_push: assert property (resultValid |->
    encapPush == (encapIndexResult != 7'h00))
    else $error("push flag disagrees with index");
  a_result_hold: assert property (!resultValid |-> $stable(labelResult)
    && $stable(statIndexResult) && $stable(diffservResult))
    else $error("results moved between frames");
endmodule // egress_action_checker

bind egress_action_field_select egress_action_checker #(.POPW(POPW)) chk_u (.*);

// >>> verif/map_lookup_model.sv
`timescale 1ns/10ps
module map_lookup_model (
  input wire logic        mapAddrValid,
  input wire logic [21:0] resourceAAddr,
  input wire logic [21:0] resourceBAddr,
  input wire logic [3:0]  hitMask,
  output logic [3:0]      mapHit,
  output logic [23:0]     mapDscp,
  output logic [11:0]     mapTc,
  output logic [79:0]     mapLabel
);
  // ********************
  // lookup answer
  // ********************
  logic [43:0] adr;
  assign adr = {resourceBAddr, resourceAAddr};
  always_comb begin
    for (int t = 0; t < 4; t++) begin
      logic [10:0] v;
      v = adr[11*t+:11] + 11'(t * 37);
      mapDscp[6*t+:6] = v[5:0];
      mapTc[3*t+:3] = v[8:6];
      mapLabel[20*t+:20] = {v, v[8:0]};
    end
    mapHit = hitMask;
    // stale answers must not look valid outside the lookup cycle
    if (!mapAddrValid) begin
      {mapHit, mapDscp, mapTc, mapLabel} = ~{mapHit, mapDscp, mapTc, mapLabel};
    end
  end
endmodule // map_lookup_model

// >>> verif/egress_action_field_select_tb.sv
`timescale 1ns/10ps
module egress_action_field_select_tb;
  import egress_action_pkg::*;
  // ********************
  // signals and reference state
  // ********************
  logic sys_clk = 0, rst_n = 0, s_axi_bready = 1, s_axi_rready = 1;
  logic [5:0]  s_axi_awaddr = 0, s_axi_araddr = 0, classDscp = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf, hitMask = 0, mapHit;
  logic frameValid = 0, classBottomStack = 0, frameDei = 0, poppedDei = 0;
  logic protActive = 0, control_word_on = 0;
  logic [11:0] classVlan = 0, mapTc, customer_tag_vlan_result;
  logic [2:0]  classTc = 0, class_of_service_id = 0, qosClass = 0;
  logic [2:0]  framePcp = 0, poppedPcp = 0, trafficClassResult;
  logic [1:0]  dropPrec = 0, s_axi_bresp, s_axi_rresp;
  logic [7:0]  classHopLimit = 0, hopLimitResult;
  logic [4:0]  headerWordPop = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, mapAddrValid, resultValid, diffservFromPort;
  logic bottomStackResult, controlWordResult, encapPush;
  logic [23:0] mapDscp;
  logic [79:0] mapLabel;
  logic [21:0] resourceAAddr, resourceBAddr;
  logic [5:0]  diffservResult, popBytesResult, lastPop = 0;
  logic [19:0] labelResult;
  logic [6:0]  encapIndexResult;
  logic [10:0] endpointIndexResult;
  logic [9:0]  statIndexResult;
  logic [31:0] rg[8];
  logic [43:0] aq[$];
  logic [86:0] rq[$];
  int seed = 32'h4cfd, n_fail = 0, num_checks = 0, cyc = 0, nRes = 0;

  egress_action_field_select dut_u (.*);
  map_lookup_model model_u (.*);
  always #5 sys_clk = ~sys_clk;

  // ********************
  // helpers
  // ********************
  task automatic chk(string n, logic [127:0] e, logic [127:0] s);
    num_checks++;
    if (e !== s) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic axw(logic [5:0] a, logic [31:0] d, logic [1:0] e);
    logic ga, gw;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    do begin
      @(negedge sys_clk);
      ga = s_axi_awvalid && s_axi_awready;
      gw = s_axi_wvalid && s_axi_wready;
      @(posedge sys_clk);
      if (ga) s_axi_awvalid <= 0;
      if (gw) s_axi_wvalid <= 0;
    end while (s_axi_awvalid && !ga || s_axi_wvalid && !gw);
    do @(negedge sys_clk); while (!s_axi_bvalid);
    chk("bresp", e, s_axi_bresp);
    @(posedge sys_clk);
  endtask
  task automatic axr(logic [5:0] a, output logic [31:0] d, input logic [1:0] e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(negedge sys_clk); while (!s_axi_arready);
    @(posedge sys_clk);
    s_axi_arvalid <= 0;
    do @(negedge sys_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    chk("rresp", e, s_axi_rresp);
    @(posedge sys_clk);
  endtask
  function automatic int ko(int k);
    int h;
    h = k == 3 ? 8 * dropPrec : k == 7 ? frameDei : k == 12 ? poppedDei
      : (16'h4a52 >> k) & 1 ? dropPrec : 0;
    return 8 * h + (k < 2 ? qosClass : k < 4 ? classDscp : k == 4 ?
      classDscp[5:3] : k < 8 ? framePcp : k < 10 ? classTc : k < 13 ?
      poppedPcp : class_of_service_id);
  endfunction
  function automatic logic [43:0] adrExp();
    logic [43:0] a;
    for (int t = 0; t < 4; t++)
      a[11*t+:11] = {rg[6][8*t+:8], 3'h0}
        + 11'(ko(rg[7][4*t+:4]));
    return a;
  endfunction
  function automatic logic [5:0] chain(int s, logic [5:0] c, logic [5:0] m[4]);
    logic [5:0] lo, hi;
    lo = hitMask[0] ? m[0] : c;
    hi = hitMask[2] ? m[2] : c;
    case (s)
      4: return lo;
      5: return hitMask[1] ? m[1] : lo;
      6: return hi;
      default: return hitMask[3] ? m[3] : hi;
    endcase
  endfunction
  function automatic logic [86:0] resExp();
    logic [43:0] a;
    logic [10:0] v[4];
    logic [5:0]  dm[4], tm[4], ds, pb, hb;
    logic [19:0] lb;
    logic [2:0]  tc;
    logic [9:0]  bs;
    logic [6:0]  e;
    logic fp, sb;
    int s, pc;
    a = adrExp();
    for (int t = 0; t < 4; t++) begin
      v[t] = a[11*t+:11] + 11'(t * 37);
      dm[t] = v[t][5:0];
      tm[t] = {3'h0, v[t][8:6]};
    end
    s = rg[0][POS_DIFFSERV_SOURCE_SELECT+:3];
    fp = s == 0 || s == 3;
    ds = s == 2 ? rg[1][POS_DSCP_CONST+:6] : s < 4 ? classDscp
       : chain(s, rg[1][POS_DSCP_CONST+:6], dm);
    s = rg[0][POS_TRAFFIC_CLASS_SOURCE+:3];
    tc = s == 1 ? rg[1][POS_TC_CONST+:3] : s == 2 ? class_of_service_id
       : s < 4 ? classTc : 3'(chain(s, 6'(rg[1][POS_TC_CONST+:3]), tm));
    s = rg[0][POS_LABEL_SEL+:3];
    lb = s > 3 && hitMask[s-4] ? {v[s-4], v[s-4][8:0]} : rg[2][19:0];
    s = rg[0][POS_PROT_SEL+:2];
    sb = s == PROT_WHEN_ON && protActive || s == PROT_WHEN_OFF && !protActive;
    e = sb ? rg[3][POS_ENCAP_PROT+:7] : rg[3][POS_ENCAP+:7];
    bs = (sb ? rg[4][POS_BASE_PROT+:10] : rg[4][POS_BASE+:10])
       + rg[5][3*class_of_service_id+:3];
    pc = rg[0][POS_POP_CNT+:5];
    hb = {headerWordPop, 1'b0};
    pb = pc == 1 ? 6'h00 : pc > 1 && pc <= POP_MAX_CODE && 2 * pc <= hb
       ? 6'(2 * pc) : hb;
    return {rg[0][POS_VLAN_SRC] ? rg[1][POS_VLAN_CONST+:12] : classVlan,
      fp, ds, lb, tc, rg[0][POS_BOS_SRC] ? rg[1][POS_BOS_CONST] : classBottomStack,
      rg[0][POS_TTL_SRC] ? rg[1][POS_TTL_CONST+:8] : classHopLimit,
      !rg[0][POS_CW_OFF] && control_word_on, e != 0, e,
      sb ? rg[3][POS_MEP_PROT+:11] : 11'h000, bs, pb};
  endfunction
  task automatic frame();
    logic [31:0] r, q;
    r = $random(seed);
    q = $random(seed);
    @(posedge sys_clk);
    frameValid <= 1;
    {classVlan, classDscp, classTc, classBottomStack, classHopLimit} <= r[29:0];
    {class_of_service_id, qosClass, dropPrec, framePcp, frameDei, poppedPcp,
      poppedDei, protActive, headerWordPop, control_word_on} <= q[22:0];
    #1;
    aq.push_back(adrExp());
    rq.push_back(resExp());
  endtask

  // ********************
  // monitor, timeout, sequence
  // ********************
  always @(negedge sys_clk) begin
    logic [86:0] e;
    if (mapAddrValid)
      chk("map addr", aq.pop_front(), {resourceBAddr, resourceAAddr});
    if (resultValid) begin
      e = rq.pop_front();
      lastPop = e[5:0];
      nRes++;
      chk("results", e, {customer_tag_vlan_result, diffservFromPort,
        diffservResult, labelResult, trafficClassResult, bottomStackResult,
        hopLimitResult, controlWordResult, encapPush, encapIndexResult,
        endpointIndexResult, statIndexResult, popBytesResult});
    end
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 8000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    logic [31:0] d;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1;
    for (int i = 0; i < 9; i++) begin
      axr(6'(4 * i), d, RESP_OKAY);
      chk("reset value", RESET_VALUE, d);
    end
    axr(6'h24, d, RESP_SLVERR);
    chk("unmapped read", 32'h0000_0000, d);
    axw(6'h3c, d, RESP_SLVERR);
    axw(OFS_STATUS, d, RESP_SLVERR);
    for (int i = 0; i < 40; i++) begin
      for (int k = 0; k < 8; k++)
        rg[k] = $random(seed);
      for (int t = 0; t < 4; t++)
        rg[7][4*t+:4] %= 4'hf;
      for (int k = 0; k < 8; k++)
        axw(6'(4 * k), rg[k], RESP_OKAY);
      hitMask <= 4'($random(seed));
      frame();
      frame();
      @(posedge sys_clk);
      frameValid <= 0;
      repeat (3) @(posedge sys_clk);
    end
    axr(OFS_STATUS, d, RESP_OKAY);
    chk("status", {10'h000, lastPop, 16'h0050}, d);
    chk("count", 80, nRes);
    complete_run();
  end
endmodule // egress_action_field_select_tb
